// *** sdfs_pkg.sv ***
`default_nettype none
package sdfs_pkg;
    // ---------------------------------------------------------
    // register map
    // ---------------------------------------------------------
    localparam logic [7:0]  SDFS_CMD_STS_OFS   = 8'h04;
    localparam logic [7:0]  SDFS_STS_OFS       = 8'h06;
    localparam logic [7:0]  SDFS_CLASS_OFS     = 8'h08;
    localparam logic [15:0] SDFS_STS_RESET     = 16'h0210;
    // ---------------------------------------------------------
    // status fields
    // ---------------------------------------------------------
    localparam int SDFS_PARITY_BIT  = 15;
    localparam int SDFS_SYSERR_BIT  = 14;
    localparam int SDFS_MASTER_ABORT_RECEIVED_BIT  = 13;
    localparam int SDFS_TABREC_BIT  = 12;
    localparam int SDFS_TABSIG_BIT  = 11;
    localparam int SDFS_DEVSEL_LSB  = 9;
    localparam int SDFS_DPAR_BIT    = 8;
    localparam int SDFS_CAPABILITY_LIST_PRESENT_BIT = 4;
    localparam int SDFS_INT_BIT     = 3;
    localparam logic [15:0] SDFS_W1C_MASK   = 16'hF900;
    localparam logic [1:0]  SDFS_DEVSEL_MED = 2'h1;
    // ---------------------------------------------------------
    // class code fields
    // ---------------------------------------------------------
    localparam logic [7:0] SDFS_BASE_CATEGORY = 8'h08;
    localparam logic [7:0] SDFS_SUBCLASS      = 8'h05;
    localparam logic [7:0] SDFS_PROGRAMMING_INTERFACE_DMA     = 8'h01;
    localparam logic [7:0] SDFS_PROGRAMMING_INTERFACE_NODMA   = 8'h00;
    // command register bit positions seen by this block
    localparam int SDFS_CMD_PERR_BIT   = 6;
    localparam int SDFS_CMD_SERR_BIT   = 8;
    localparam int SDFS_CMD_INTDIS_BIT = 10;
endpackage
`default_nettype wire

// *** sdfs_status_class.sv ***
`default_nettype none
module sdfs_status_class
    import sdfs_pkg::*;
#(
    parameter int         INT_SRC_N    = 4,
    // arbitrary revision value
    parameter logic [7:0] SILICON_REV  = 8'h5A
) (
    input  wire logic                 clk_sys_in,   // system clock
    input  wire logic                 rst_in,       // async reset
    input  wire logic                 cfg_rd_in,    // config read
    input  wire logic                 cfg_wr_in,    // config write
    input  wire logic [7:0]           cfg_addr_in,  // byte address
    input  wire logic [3:0]           cfg_be_in,    // byte enables
    input  wire logic [31:0]          cfg_wdata_in, // write data
    output logic      [31:0]          cfg_rdata_out,// read data
    output logic                      cfg_ack_out,  // access done
    input  wire logic [15:0]          command_in,   // command reg
    input  wire logic                 dma_enable_in,// general ctrl
    input  wire logic                 addr_parity_error_detected_in, // addr parity
    input  wire logic                 data_parity_error_detected_in, // data parity
    input  wire logic                 system_error_signalled_in,   // serr driven
    input  wire logic                 master_abort_received_in,    // master abort
    input  wire logic                 tabort_rx_in, // target abort rx
    input  wire logic                 tabort_tx_in, // target abort tx
    input  wire logic                 perr_seen_in, // perr on bus
    input  wire logic                 master_phase_in, // own data ph
    input  wire logic [INT_SRC_N-1:0] int_cond_in,  // int sources
    input  wire logic [INT_SRC_N-1:0] int_enable_in,// source enables
    output logic                      intx_out,     // interrupt req
    output logic                      perr_drive_out,// drive perr
    output logic      [1:0]           devsel_speed_out // decode speed
);
    // the sources meet in one reduction-or; a word wide is the limit
    if (INT_SRC_N < 1 || INT_SRC_N > 32) begin : g_bad_int_src_n
        $error("INT_SRC_N out of range");
    end

    // ---------------------------------------------------------
    // decoding
    // ---------------------------------------------------------
    function automatic logic hits(input logic [7:0] a,
                                  input logic [7:0] ofs);
        hits = (a[7:2] == ofs[7:2]);
    endfunction

    logic [15:0] sticky;
    wire logic [15:0] next_sticky;
    logic [15:0] set_evt;
    logic [15:0] clr_req;
    logic [15:0] status_view;
    logic        int_status;
    logic [7:0]  prog_if;
    logic        sts_wr;

    assign sts_wr = cfg_wr_in && hits(cfg_addr_in, SDFS_STS_OFS);

    // ---------------------------------------------------------
    // event sources
    // ---------------------------------------------------------
    always_comb begin
        set_evt = '0;
        set_evt[SDFS_PARITY_BIT] = addr_parity_error_detected_in
                                 | data_parity_error_detected_in;
        set_evt[SDFS_SYSERR_BIT] = system_error_signalled_in
                                 & command_in[SDFS_CMD_SERR_BIT];
        set_evt[SDFS_MASTER_ABORT_RECEIVED_BIT] = master_abort_received_in;
        set_evt[SDFS_TABREC_BIT] = tabort_rx_in;
        set_evt[SDFS_TABSIG_BIT] = tabort_tx_in;
        set_evt[SDFS_DPAR_BIT]   = perr_seen_in & master_phase_in
                                 & command_in[SDFS_CMD_PERR_BIT];
    end

    // status occupies the upper half of the dword at 04h
    always_comb begin
        clr_req = '0;
        if (sts_wr) begin
            clr_req[7:0]  = cfg_be_in[2] ? cfg_wdata_in[23:16] : 8'h00;
            clr_req[15:8] = cfg_be_in[3] ? cfg_wdata_in[31:24] : 8'h00;
        end
        clr_req = clr_req & SDFS_W1C_MASK;
    end

    // ---------------------------------------------------------
    // sticky flags, one per error bit
    // ---------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_bit
            if (SDFS_W1C_MASK[gi]) begin : g_sticky
                // set term first so a same-cycle clear loses
                assign next_sticky[gi] = set_evt[gi]
                                       | (sticky[gi] & ~clr_req[gi]);
            end else begin : g_fixed
                assign next_sticky[gi] = 1'b0;
            end
        end
    endgenerate

    // one process owns the whole vector, so no bit has two drivers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sticky <= SDFS_STS_RESET & SDFS_W1C_MASK;
        end else begin
            sticky <= next_sticky;
        end
    end

    // ---------------------------------------------------------
    // interrupt status and pin
    // ---------------------------------------------------------
    // a level view of the enabled sources; the disable bit is
    // deliberately kept out so software can poll while masked
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            int_status <= 1'b0;
        end else begin
            int_status <= |(int_cond_in & int_enable_in);
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            intx_out <= 1'b0;
        end else begin
            intx_out <= (|(int_cond_in & int_enable_in))
                      & ~command_in[SDFS_CMD_INTDIS_BIT];
        end
    end

    // ---------------------------------------------------------
    // parity error driver gate
    // ---------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            perr_drive_out <= 1'b0;
        end else begin
            perr_drive_out <= data_parity_error_detected_in
                            & command_in[SDFS_CMD_PERR_BIT];
        end
    end

    assign devsel_speed_out = SDFS_DEVSEL_MED;

    // ---------------------------------------------------------
    // read view
    // ---------------------------------------------------------
    always_comb begin
        status_view = sticky;
        status_view[SDFS_DEVSEL_LSB +: 2] = SDFS_DEVSEL_MED;
        status_view[7:5] = 3'h0;
        status_view[SDFS_CAPABILITY_LIST_PRESENT_BIT] = 1'b1;
        status_view[SDFS_INT_BIT] = int_status;
        status_view[2:0] = 3'h0;
    end

    assign prog_if = dma_enable_in ? SDFS_PROGRAMMING_INTERFACE_DMA
                                   : SDFS_PROGRAMMING_INTERFACE_NODMA;

    // answer one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_rdata_out <= 32'h0000_0000;
        end else if (cfg_rd_in) begin
            if (hits(cfg_addr_in, SDFS_CMD_STS_OFS)) begin
                cfg_rdata_out <= {status_view, command_in};
            end else if (hits(cfg_addr_in, SDFS_CLASS_OFS)) begin
                cfg_rdata_out <= {SDFS_BASE_CATEGORY, SDFS_SUBCLASS,
                                  prog_if, SILICON_REV};
            end else begin
                cfg_rdata_out <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_ack_out <= 1'b0;
        end else begin
            cfg_ack_out <= cfg_rd_in | cfg_wr_in;
        end
    end

    // ---------------------------------------------------------
    // checks
    // ---------------------------------------------------------
    w1c_clear_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (sts_wr && cfg_be_in[3] && cfg_wdata_in[31]
         && !addr_parity_error_detected_in && !data_parity_error_detected_in)
        |=> !sticky[SDFS_PARITY_BIT])
        else $error("parity flag not cleared by write of one");

    w1c_zero_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (sticky[SDFS_MASTER_ABORT_RECEIVED_BIT] && !(sts_wr && cfg_be_in[3]
         && cfg_wdata_in[29])) |=> sticky[SDFS_MASTER_ABORT_RECEIVED_BIT])
        else $error("master abort flag lost without clear");

    set_wins_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (tabort_tx_in && sts_wr) |=> sticky[SDFS_TABSIG_BIT])
        else $error("set event lost to clear");

    syserr_gate_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (!sticky[SDFS_SYSERR_BIT] && system_error_signalled_in
         && !command_in[SDFS_CMD_SERR_BIT])
        |=> !sticky[SDFS_SYSERR_BIT])
        else $error("system error flag set while disabled");

    dpar_set_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (perr_seen_in && master_phase_in
         && command_in[SDFS_CMD_PERR_BIT])
        |=> sticky[SDFS_DPAR_BIT])
        else $error("data parity flag not set");

    status_fixed_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (cfg_rd_in && hits(cfg_addr_in, SDFS_STS_OFS))
        |=> cfg_rdata_out[26:25] == SDFS_DEVSEL_MED
            && cfg_rdata_out[23:20] == 4'h1
            && cfg_rdata_out[18:16] == 3'h0)
        else $error("hardwired status bits wrong");

    intx_gate_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 intx_out == (int_status
             && !$past(command_in[SDFS_CMD_INTDIS_BIT])))
        else $error("interrupt output mismatch");

    class_read_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (cfg_rd_in && hits(cfg_addr_in, SDFS_CLASS_OFS))
        |=> cfg_rdata_out == {16'h0805,
             $past(dma_enable_in) ? 8'h01 : 8'h00, SILICON_REV})
        else $error("class register read wrong");

    perr_drive_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        perr_drive_out |-> $past(command_in[SDFS_CMD_PERR_BIT]))
        else $error("parity driven while response disabled");

    parity_set_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (addr_parity_error_detected_in || data_parity_error_detected_in)
        |=> sticky[SDFS_PARITY_BIT])
        else $error("parity flag not set");

    master_abort_received_set_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        master_abort_received_in |=> sticky[SDFS_MASTER_ABORT_RECEIVED_BIT])
        else $error("master abort flag not set");

    tabort_rx_set_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        tabort_rx_in |=> sticky[SDFS_TABREC_BIT])
        else $error("received target abort flag not set");

    tabort_tx_set_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        tabort_tx_in |=> sticky[SDFS_TABSIG_BIT])
        else $error("signalled target abort flag not set");

    upper_keep_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (sts_wr && !cfg_be_in[3] && sticky[SDFS_PARITY_BIT])
        |=> sticky[SDFS_PARITY_BIT])
        else $error("parity flag cleared without its byte enable");

    int_level_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 int_status == (|($past(int_cond_in) & $past(int_enable_in))))
        else $error("interrupt status does not follow enabled sources");

    intdis_block_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        command_in[SDFS_CMD_INTDIS_BIT] |=> !intx_out)
        else $error("interrupt output active while disabled");

    // no disable here: the check is about the reset itself
    reset_value_a: assert property (
        @(posedge clk_sys_in)
        (rst_in && $past(rst_in))
        |-> sticky == (SDFS_STS_RESET & SDFS_W1C_MASK))
        else $error("status flags not at reset value");

endmodule
`default_nettype wire

// *** sdfs_host_model.sv ***
`default_nettype none
module sdfs_host_model (
    input  wire logic        clk_sys_in,   // system clock
    output logic             cfg_rd_out,   // read strobe
    output logic             cfg_wr_out,   // write strobe
    output logic [7:0]       cfg_addr_out, // byte address
    output logic [3:0]       cfg_be_out,   // byte enables
    output logic [31:0]      cfg_wdata_out // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cfg_rd_out = 1'b0;
        cfg_wr_out = 1'b0;
        cfg_addr_out = 8'hFF;
        cfg_be_out = 4'h0;
        cfg_wdata_out = 32'h0;
    end
    // called at a falling edge; the strobe is held over one rising edge,
    // then one idle edge passes so a next call never reassigns a strobe
    // in the same step. released lines show the inverse so a stale value
    // never looks valid
    task automatic access(input logic wr, input logic [7:0] addr,
                          input logic [3:0] be, input logic [31:0] data);
        cfg_rd_out = ~wr;
        cfg_wr_out = wr;
        cfg_addr_out = addr;
        cfg_be_out = be;
        cfg_wdata_out = data;
        @(negedge clk_sys_in);
        cfg_rd_out = 1'b0;
        cfg_wr_out = 1'b0;
        cfg_addr_out = ~addr;
        cfg_be_out = ~be;
        cfg_wdata_out = ~data;
        @(negedge clk_sys_in);
    endtask
endmodule
`default_nettype wire

// *** sdfs_status_class_bench.sv ***
`default_nettype none
module sdfs_status_class_bench
    import sdfs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REV = 8'h3C; // arbitrary revision value
    localparam logic [7:0] EV_T [10] = '{8'h80, 8'h40, 8'h20, 8'h20,
        8'h10, 8'h08, 8'h04, 8'h03, 8'h02, 8'h01};
    localparam logic [15:0] CMD_T [10] = '{16'h0, 16'h0, 16'h0100, 16'h0,
        16'h0, 16'h0, 16'h0, 16'h0040, 16'h0040, 16'h0040};
    localparam logic [15:0] EXP_T [10] = '{16'h8000, 16'h8000, 16'h4000,
        16'h0, 16'h2000, 16'h1000, 16'h0800, 16'h0100, 16'h0, 16'h0};
    logic        clk_sys_in, rst_in, cfg_rd_in, cfg_wr_in, cfg_ack_out;
    logic [7:0]  cfg_addr_in, ev;
    logic [3:0]  cfg_be_in, int_cond_in, int_enable_in;
    logic [31:0] cfg_wdata_in, cfg_rdata_out, seed, r, got, last_rd;
    logic [15:0] command_in, sts;
    logic        dma_enable_in, intx_out, perr_drive_out;
    logic [1:0]  devsel_speed_out;
    logic [63:0] note_q [$];
    logic [63:0] note;
    int          n_fail = 0;
    int          num_checks = 0;
    sdfs_status_class #(.INT_SRC_N(4), .SILICON_REV(REV))
        sdfs_status_class_inst (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cfg_rd_in(cfg_rd_in),
        .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in),
        .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
        .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out),
        .command_in(command_in), .dma_enable_in(dma_enable_in),
        .addr_parity_error_detected_in(ev[7]), .data_parity_error_detected_in(ev[6]),
        .system_error_signalled_in(ev[5]), .master_abort_received_in(ev[4]), .tabort_rx_in(ev[3]),
        .tabort_tx_in(ev[2]), .perr_seen_in(ev[1]),
        .master_phase_in(ev[0]), .int_cond_in(int_cond_in),
        .int_enable_in(int_enable_in), .intx_out(intx_out),
        .perr_drive_out(perr_drive_out),
        .devsel_speed_out(devsel_speed_out));
    sdfs_host_model sdfs_host_model_inst (
        .clk_sys_in(clk_sys_in), .cfg_rd_out(cfg_rd_in),
        .cfg_wr_out(cfg_wr_in), .cfg_addr_out(cfg_addr_in),
        .cfg_be_out(cfg_be_in), .cfg_wdata_out(cfg_wdata_in));
    // ---------------------------------------------------------
    // helpers
    // ---------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // the note holds a mask of the bits to compare and their value
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        last_rd = exp;
        note_q.push_back({32'hFFFF_FFFF, exp});
        sdfs_host_model_inst.access(1'b0, a, 4'hF, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        // a write leaves the last read data standing
        note_q.push_back({32'hFFFF_FFFF, last_rd});
        sdfs_host_model_inst.access(1'b1, a, be, d);
    endtask
    task automatic finish_test();
        check("pending_notes", 32'(note_q.size()), 32'h0);
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ---------------------------------------------------------
    // clock, watchdog and result monitor
    // ---------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
    initial forever begin
        @(negedge clk_sys_in);
        if (cfg_ack_out === 1'b1 && note_q.size() > 0) begin
            note = note_q.pop_front();
            got = note[63:32] & cfg_rdata_out;
            check("cfg_rdata", got, note[31:0]);
        end
    end
    // ---------------------------------------------------------
    // stimulus
    // ---------------------------------------------------------
    initial begin
        seed = 32'hC54E;
        rst_in = 1'b1;
        command_in = 16'h0;
        dma_enable_in = 1'b0;
        ev = 8'h0;
        int_cond_in = 4'h0;
        int_enable_in = 4'h0;
        repeat (6) @(negedge clk_sys_in);
        rst_in = 1'b0;
        check("devsel", {30'h0, devsel_speed_out}, 32'h1);
        rd(8'h06, {SDFS_STS_RESET, 16'h0});
        for (int d = 0; d < 2; d++) begin
            dma_enable_in = d[0];
            rd(SDFS_CLASS_OFS, {16'h0805, 7'h0, d[0], REV});
        end
        rd(8'h0C, 32'h0);
        for (int i = 0; i < 10; i++) begin
            command_in = CMD_T[i];
            ev = EV_T[i];
            @(negedge clk_sys_in);
            ev = 8'h0;
            sts = SDFS_STS_RESET | EXP_T[i];
            rd(8'h04, {sts, command_in});
            wr(8'h06, 4'hC, 32'h0);
            rd(8'h04, {sts, command_in});
            wr(8'h06, 4'hC, 32'hFFFF_0000);
            rd(8'h04, {SDFS_STS_RESET, command_in});
        end
        // set event lands in the very cycle of the clearing write
        // the event must be gone by the next edge, or it sets again
        ev = 8'h10;
        fork
            wr(8'h04, 4'hC, 32'h2000_0000);
            begin
                @(negedge clk_sys_in);
                ev = 8'h0;
            end
        join
        rd(8'h04, {16'h2210, command_in});
        wr(8'h04, 4'h4, 32'hFFFF_0000);
        rd(8'h04, {16'h2210, command_in});
        wr(8'h04, 4'h8, 32'hFFFF_0000);
        for (int p = 0; p < 2; p++) begin
            command_in = {9'h0, p[0], 6'h0};
            ev = 8'h40;
            @(negedge clk_sys_in);
            ev = 8'h0;
            check("perr_drive", 32'(perr_drive_out), 32'(p[0]));
            wr(8'h06, 4'hC, 32'h8000_0000);
        end
        // a reset in mid-run brings every flag back to its reset value
        ev = 8'h90;
        @(negedge clk_sys_in);
        ev = 8'h0;
        rst_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        rst_in = 1'b0;
        rd(8'h06, {SDFS_STS_RESET, command_in});
        for (int i = 0; i < 8; i++) begin
            r = xs();
            int_cond_in = r[3:0];
            int_enable_in = r[7:4];
            command_in = {5'h0, r[8], 10'h0};
            dma_enable_in = r[9];
            @(negedge clk_sys_in);
            sts = {12'h021, |(r[3:0] & r[7:4]), 3'h0};
            check("intx", 32'(intx_out), 32'(sts[3] & ~r[8]));
            rd(8'h04, {sts, command_in});
        end
        repeat (3) @(negedge clk_sys_in);
        finish_test();
    end
endmodule
`default_nettype wire
